// ===== verilog/bml_pkg.sv
// Shared constants and types of the boot mode loader.
package bml_pkg;
   localparam int BML_AW = 8;
   localparam logic [7:0] BML_OFF_MODE = 8'h00;
   localparam logic [7:0] BML_OFF_CTRL = 8'h04;
   localparam logic [7:0] BML_OFF_STATUS = 8'h08;
   localparam logic [7:0] BML_OFF_WORDS = 8'h0c;
   localparam logic [7:0] BML_OFF_START = 8'h10;
   localparam int BML_CTRL_GO = 0;
   localparam int BML_ST_BUSY = 0;
   localparam int BML_ST_DONE = 1;
   localparam int BML_ST_EXP = 2;
   localparam logic [1:0] BML_RESP_OKAY = 2'h0;
   localparam logic [1:0] BML_RESP_SLVERR = 2'h2;
   localparam logic [23:0] BML_BOOT_ENTRY = 24'hff0000;
   localparam logic [23:0] BML_EXP_START = 24'hc00000;
   localparam logic [23:0] BML_MEM_BASE = 24'hd00000;
   localparam logic [17:0] BML_EXP_PORT_ADDR = 18'h00000;
   localparam logic [4:0] BML_WAIT_STATES = 5'h1f;
   localparam logic [3:0] BML_MODE_EXP = 4'h0;
   localparam logic [3:0] BML_MODE_MEM = 4'h1;
   localparam logic [3:0] BML_MODE_SER = 4'h2;
   localparam logic [3:0] BML_MODE_HOST = 4'h4;
   localparam logic [3:0] BML_MODE_EXP8 = 4'h8;
   localparam logic [3:0] BML_MODE_RESET = 4'h0;
   localparam logic [1:0] BML_LAST_BYTE = 2'h2;
   localparam logic [3:0] BML_TICK_HALF = 4'h8;
   localparam logic [3:0] BML_TICK_LAST = 4'hf;
   localparam logic [3:0] BML_STOP_BIT = 4'h9;
   typedef enum logic [2:0] {ST_IDLE, ST_EXPAND, ST_MEM, ST_SER, ST_HOST} bml_state_t;
   typedef enum logic [1:0] {PH_COUNT, PH_ADDR, PH_DATA} bml_phase_t;
endpackage : bml_pkg

// ===== verilog/bml_ser_if.sv
// Byte link between the loader core and its serial port.
`timescale 1ns/1ps
`default_nettype none
interface bml_ser_if;
   logic en;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic tx_start;
   logic [7:0] tx_byte;
   logic tx_busy;
   modport loader(output en, tx_start, tx_byte, input rx_valid, rx_byte, tx_busy);
   modport port(input en, tx_start, tx_byte, output rx_valid, rx_byte, tx_busy);
endinterface : bml_ser_if
`default_nettype wire

// ===== verilog/bml_sci.sv
// Asynchronous serial port, 8 data bits, 1 stop bit, no parity, 16x external clock.
`timescale 1ns/1ps
`default_nettype none
module bml_sci (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Serial pins.
   input wire logic ser_clk,
   input wire logic ser_rxd,
   output logic ser_txd,
   // Byte side.
   bml_ser_if.port ser
);
   import bml_pkg::*;
   logic clk_q, rx_on, tx_on, rx_valid;
   logic [3:0] rx_cnt, rx_bit, tx_cnt, tx_bit;
   logic [7:0] rx_sh;
   logic [9:0] tx_sh;
   logic next_clk_q, next_rx_on, next_tx_on, next_rx_valid;
   logic [3:0] next_rx_cnt, next_rx_bit, next_tx_cnt, next_tx_bit;
   logic [7:0] next_rx_sh;
   logic [9:0] next_tx_sh;
   logic tick;

   // The pin is taken as synchronous, so its rising edge is one tick of the 16x clock.
   assign tick = ser_clk && !clk_q;
   assign ser.rx_valid = rx_valid;
   assign ser.rx_byte = rx_sh;
   assign ser.tx_busy = tx_on;
   assign ser_txd = tx_sh[0];

   always_comb begin
      next_clk_q = ser_clk;
      next_rx_on = rx_on;
      next_rx_cnt = rx_cnt;
      next_rx_bit = rx_bit;
      next_rx_sh = rx_sh;
      next_rx_valid = 1'b0;
      next_tx_on = tx_on;
      next_tx_cnt = tx_cnt;
      next_tx_bit = tx_bit;
      next_tx_sh = tx_sh;
      if (!ser.en) begin
         next_rx_on = 1'b0;
      end else if (tick) begin
         if (!rx_on) begin
            if (!ser_rxd) begin
               // Starting half way through the tick count samples each bit mid-cell.
               next_rx_on = 1'b1;
               next_rx_cnt = BML_TICK_HALF;
               next_rx_bit = 4'h0;
            end
         end else begin
            next_rx_cnt = rx_cnt + 4'h1;
            if (rx_cnt == BML_TICK_LAST) begin
               next_rx_bit = rx_bit + 4'h1;
               if (rx_bit == 4'h0) begin
                  next_rx_on = !ser_rxd;
               end else if (rx_bit == BML_STOP_BIT) begin
                  // A frame without a high stop bit is dropped.
                  next_rx_on = 1'b0;
                  next_rx_valid = ser_rxd;
               end else begin
                  next_rx_sh = {ser_rxd, rx_sh[7:1]};
               end
            end
         end
      end
      if (ser.tx_start && !tx_on) begin
         next_tx_sh = {1'b1, ser.tx_byte, 1'b0};
         next_tx_on = 1'b1;
         next_tx_cnt = 4'h0;
         next_tx_bit = 4'h0;
      end else if (tx_on && tick) begin
         next_tx_cnt = tx_cnt + 4'h1;
         if (tx_cnt == BML_TICK_LAST) begin
            next_tx_sh = {1'b1, tx_sh[9:1]};
            next_tx_bit = tx_bit + 4'h1;
            next_tx_on = tx_bit != BML_STOP_BIT;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_q <= 1'b0;
         rx_on <= 1'b0;
         rx_cnt <= 4'h0;
         rx_bit <= 4'h0;
         rx_sh <= 8'h00;
         rx_valid <= 1'b0;
         tx_on <= 1'b0;
         tx_cnt <= 4'h0;
         tx_bit <= 4'h0;
         tx_sh <= 10'h3ff;
      end else begin
         clk_q <= next_clk_q;
         rx_on <= next_rx_on;
         rx_cnt <= next_rx_cnt;
         rx_bit <= next_rx_bit;
         rx_sh <= next_rx_sh;
         rx_valid <= next_rx_valid;
         tx_on <= next_tx_on;
         tx_cnt <= next_tx_cnt;
         tx_bit <= next_tx_bit;
         tx_sh <= next_tx_sh;
      end
   end
endmodule : bml_sci
`default_nettype wire

// ===== verilog/bml_loader.sv
// Boot mode capture and bootstrap loader with an AXI4-Lite register slave.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bml_loader (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite register slave.
   input wire logic [bml_pkg::BML_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [bml_pkg::BML_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Mode pins.
   input wire logic mode_pin_a,
   input wire logic mode_pin_b,
   input wire logic mode_pin_c,
   input wire logic mode_pin_d,
   // External memory port.
   output logic [17:0] ext_addr,
   output logic ext_rd,
   output logic ext_attr_one,
   output logic ext_static,
   output logic [4:0] ext_wait,
   input wire logic [7:0] ext_data,
   // Asynchronous serial port pins.
   input wire logic ser_clk,
   input wire logic ser_rxd,
   output logic ser_txd,
   // Host port words.
   input wire logic host_valid,
   input wire logic [23:0] host_word,
   output logic host_ready,
   input wire logic host_flag_zero,
   // Program RAM write port.
   output logic program_ram_we,
   output logic [23:0] program_ram_addr,
   output logic [23:0] program_ram_data,
   // Execution start.
   output logic exec_valid,
   output logic [23:0] exec_addr
);
   import bml_pkg::*;

   function automatic logic bml_hit(input logic [BML_AW-1:0] a);
      return a == BML_OFF_MODE || a == BML_OFF_CTRL || a == BML_OFF_STATUS ||
             a == BML_OFF_WORDS || a == BML_OFF_START;
   endfunction : bml_hit

   bml_state_t state, next_state;
   bml_phase_t phase, next_phase;
   logic cap, pend, done, aw_got, w_got;
   logic next_cap, next_pend, next_done, next_aw_got, next_w_got, next_bvalid;
   logic [3:0] mode, next_mode;
   logic [1:0] idx, next_idx, next_bresp;
   logic [23:0] acc, count, start, ptr, moff;
   logic [23:0] next_acc, next_count, next_start, next_ptr, next_moff;
   logic [4:0] wcnt, next_wcnt, next_ext_wait;
   logic [BML_AW-1:0] awa, next_awa;
   logic [31:0] wd, next_wd;
   logic [3:0] wst, next_wst;
   logic [17:0] next_ext_addr;
   logic next_ext_rd, next_ext_attr_one, next_ext_static;
   logic next_program_ram_we, next_exec_valid;
   logic [23:0] next_program_ram_addr, next_program_ram_data, next_exec_addr;
   logic next_rvalid;
   logic [31:0] next_rdata, st_word;
   logic [1:0] next_rresp;
   logic byte_v, word_v, busy, wr_do, wr_go;
   logic [7:0] byte_d;
   logic [23:0] word_d, mem_badr;
   bml_ser_if ser_l ();

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   bml_sci u_sci (
      .aclk(aclk),
      .aresetn(aresetn),
      .ser_clk(ser_clk),
      .ser_rxd(ser_rxd),
      .ser_txd(ser_txd),
      .ser(ser_l.port)
   );

   assign busy = pend || state == ST_MEM || state == ST_SER || state == ST_HOST;
   assign mem_badr = BML_MEM_BASE + moff;
   assign awready = !aw_got && !bvalid;
   assign wready = !w_got && !bvalid;
   assign arready = !rvalid;
   assign host_ready = state == ST_HOST && !host_flag_zero;
   assign ser_l.en = state == ST_SER;
   assign ser_l.tx_start = state == ST_SER && ser_l.rx_valid;
   assign ser_l.tx_byte = ser_l.rx_byte;
   assign wr_do = aw_got && w_got && !bvalid;
   assign wr_go = wr_do && awa == BML_OFF_CTRL && wst[0] && wd[BML_CTRL_GO];

   always_comb begin
      st_word = 32'h0;
      st_word[BML_ST_BUSY] = busy;
      st_word[BML_ST_DONE] = done;
      st_word[BML_ST_EXP] = state == ST_EXPAND;
   end

   // Register read path; the data is captured with the address and held unchanged until rready takes it.
   always_comb begin
      next_rvalid = rvalid && !rready;
      next_rdata = rdata;
      next_rresp = rresp;
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = bml_hit(araddr) ? BML_RESP_OKAY : BML_RESP_SLVERR;
         unique case (araddr)
            BML_OFF_MODE: next_rdata = {28'h0, mode};
            BML_OFF_STATUS: next_rdata = st_word;
            BML_OFF_WORDS: next_rdata = {8'h0, count};
            BML_OFF_START: next_rdata = {8'h0, start};
            default: next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= BML_RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   always_comb begin
      next_state = state;
      next_phase = phase;
      next_cap = 1'b1;
      next_pend = pend;
      next_done = done;
      next_mode = mode;
      next_idx = idx;
      next_acc = acc;
      next_count = count;
      next_start = start;
      next_ptr = ptr;
      next_moff = moff;
      next_wcnt = wcnt;
      next_ext_addr = ext_addr;
      next_ext_rd = ext_rd;
      next_ext_attr_one = ext_attr_one;
      next_ext_static = ext_static;
      next_ext_wait = ext_wait;
      next_program_ram_we = 1'b0;
      next_program_ram_addr = program_ram_addr;
      next_program_ram_data = program_ram_data;
      next_exec_valid = 1'b0;
      next_exec_addr = exec_addr;
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_awa = awa;
      next_wd = wd;
      next_wst = wst;
      next_bvalid = bvalid && !bready;
      next_bresp = bresp;
      byte_v = 1'b0;
      byte_d = ext_data;
      word_v = 1'b0;
      word_d = host_word;
      if (awvalid && awready) begin
         next_aw_got = 1'b1;
         next_awa = awaddr;
      end
      if (wvalid && wready) begin
         next_w_got = 1'b1;
         next_wd = wdata;
         next_wst = wstrb;
      end
      if (wr_do) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = bml_hit(awa) ? BML_RESP_OKAY : BML_RESP_SLVERR;
         if (awa == BML_OFF_MODE && wst[0]) begin
            next_mode = wd[3:0];
         end
         // A jump during a load, or in the two expanded modes, has no effect.
         if (wr_go && !busy && mode != BML_MODE_EXP && mode != BML_MODE_EXP8) begin
            next_pend = 1'b1;
         end
      end
      if (!cap) begin
         next_mode = {mode_pin_d, mode_pin_c, mode_pin_b, mode_pin_a};
         next_pend = 1'b1;
      end
      if (pend && (state == ST_IDLE || state == ST_EXPAND)) begin
         next_pend = 1'b0;
         next_done = 1'b0;
         next_phase = PH_COUNT;
         next_idx = 2'h0;
         next_moff = 24'h0;
         next_ext_attr_one = 1'b0;
         unique case (mode)
            BML_MODE_EXP: begin
               next_state = ST_EXPAND;
               next_exec_valid = 1'b1;
               next_exec_addr = BML_EXP_START;
               next_ext_static = 1'b1;
               next_ext_wait = BML_WAIT_STATES;
               next_ext_addr = BML_EXP_PORT_ADDR;
            end
            BML_MODE_MEM: begin
               next_state = ST_MEM;
               next_ext_static = 1'b1;
               next_ext_wait = BML_WAIT_STATES;
            end
            BML_MODE_SER: next_state = ST_SER;
            BML_MODE_HOST: next_state = ST_HOST;
            default: begin
               next_state = ST_IDLE;
               next_done = 1'b1;
            end
         endcase
      end
      unique case (state)
         ST_MEM: begin
            if (!ext_rd) begin
               next_ext_rd = 1'b1;
               next_ext_attr_one = 1'b1;
               next_ext_addr = mem_badr[17:0];
               next_wcnt = 5'h0;
            end else if (wcnt == BML_WAIT_STATES) begin
               next_ext_rd = 1'b0;
               next_moff = moff + 24'h1;
               byte_v = 1'b1;
               byte_d = ext_data;
            end else begin
               next_wcnt = wcnt + 5'h1;
            end
         end
         ST_SER: begin
            byte_v = ser_l.rx_valid;
            byte_d = ser_l.rx_byte;
         end
         default: ;
      endcase
      if (byte_v) begin
         next_acc = {byte_d, acc[23:8]};
         next_idx = idx + 2'h1;
         if (idx == BML_LAST_BYTE) begin
            next_idx = 2'h0;
            word_v = 1'b1;
            word_d = {byte_d, acc[23:8]};
         end
      end
      if (state == ST_HOST) begin
         word_v = host_valid && !host_flag_zero;
         word_d = host_word;
      end
      if (state == ST_HOST && host_flag_zero) begin
         next_state = ST_IDLE;
         next_done = 1'b1;
         next_exec_valid = 1'b1;
         next_exec_addr = start;
      end else if (word_v) begin
         unique case (phase)
            PH_COUNT: begin
               next_count = word_d;
               next_phase = PH_ADDR;
            end
            PH_ADDR: begin
               next_start = word_d;
               next_ptr = word_d;
               next_phase = PH_DATA;
            end
            PH_DATA: begin
               next_program_ram_we = 1'b1;
               next_program_ram_addr = ptr;
               next_program_ram_data = word_d;
               next_ptr = ptr + 24'h1;
               next_count = count - 24'h1;
            end
            default: ;
         endcase
         if ((phase == PH_ADDR && count == 24'h0) || (phase == PH_DATA && count == 24'h1)) begin
            next_state = ST_IDLE;
            next_done = 1'b1;
            next_ext_rd = 1'b0;
            next_exec_valid = 1'b1;
            next_exec_addr = phase == PH_ADDR ? word_d : start;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         phase <= PH_COUNT;
         cap <= 1'b0;
         pend <= 1'b0;
         done <= 1'b0;
         mode <= BML_MODE_RESET;
         idx <= 2'h0;
         acc <= 24'h0;
         count <= 24'h0;
         start <= 24'h0;
         ptr <= 24'h0;
         moff <= 24'h0;
         wcnt <= 5'h0;
         ext_addr <= 18'h0;
         ext_rd <= 1'b0;
         ext_attr_one <= 1'b0;
         ext_static <= 1'b0;
         ext_wait <= 5'h0;
         program_ram_we <= 1'b0;
         program_ram_addr <= 24'h0;
         program_ram_data <= 24'h0;
         exec_valid <= 1'b0;
         exec_addr <= BML_BOOT_ENTRY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         awa <= '0;
         wd <= 32'h0;
         wst <= 4'h0;
         bvalid <= 1'b0;
         bresp <= BML_RESP_OKAY;
      end else begin
         state <= next_state;
         phase <= next_phase;
         cap <= next_cap;
         pend <= next_pend;
         done <= next_done;
         mode <= next_mode;
         idx <= next_idx;
         acc <= next_acc;
         count <= next_count;
         start <= next_start;
         ptr <= next_ptr;
         moff <= next_moff;
         wcnt <= next_wcnt;
         ext_addr <= next_ext_addr;
         ext_rd <= next_ext_rd;
         ext_attr_one <= next_ext_attr_one;
         ext_static <= next_ext_static;
         ext_wait <= next_ext_wait;
         program_ram_we <= next_program_ram_we;
         program_ram_addr <= next_program_ram_addr;
         program_ram_data <= next_program_ram_data;
         exec_valid <= next_exec_valid;
         exec_addr <= next_exec_addr;
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         awa <= next_awa;
         wd <= next_wd;
         wst <= next_wst;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
      end
   end

   property p_capture;
      $rose(aresetn) |=> mode == $past({mode_pin_d, mode_pin_c, mode_pin_b, mode_pin_a});
   endproperty
   a_capture: assert property (p_capture) else $error("mode bits not taken from pins");
   property p_jump_skip;
      wr_go && !pend && (mode == BML_MODE_EXP || mode == BML_MODE_EXP8) |=> !pend;
   endproperty
   a_jump_skip: assert property (p_jump_skip) else $error("jump ran in mode 0 or 8");
   property p_mode0;
      state == ST_IDLE && pend && mode == BML_MODE_EXP |=> exec_valid &&
         exec_addr == BML_EXP_START && ext_addr == BML_EXP_PORT_ADDR &&
         ext_wait == BML_WAIT_STATES && ext_static && !ext_attr_one;
   endproperty
   a_mode0: assert property (p_mode0) else $error("expanded start wrong");
   property p_mem_ctl;
      ext_rd |-> ext_attr_one && ext_wait == BML_WAIT_STATES && ext_addr == mem_badr[17:0];
   endproperty
   a_mem_ctl: assert property (p_mem_ctl) else $error("byte memory access setup wrong");
   property p_mem_hold;
      $rose(ext_rd) |-> ##31 ext_rd ##1 !ext_rd;
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("byte read not 31 wait states");
   property p_order;
      phase == PH_COUNT && word_v |=> phase == PH_ADDR && count == $past(word_d);
   endproperty
   a_order: assert property (p_order) else $error("count word not taken first");
   property p_byte;
      byte_v && idx != BML_LAST_BYTE |=> acc[23:16] == $past(byte_d) && idx == $past(idx) + 2'h1;
   endproperty
   a_byte: assert property (p_byte) else $error("byte not packed low first");
   property p_pack;
      phase == PH_DATA && word_v && !(state == ST_HOST && host_flag_zero) |=>
         program_ram_we && program_ram_data == $past(word_d) && program_ram_addr == $past(ptr);
   endproperty
   a_pack: assert property (p_pack) else $error("program word not stored");
   property p_last;
      phase == PH_DATA && word_v && count == 24'h1 |=>
         exec_valid && exec_addr == start && state == ST_IDLE;
   endproperty
   a_last: assert property (p_last) else $error("execution not at start address");
   property p_echo;
      state == ST_SER && ser_l.rx_valid |=> ser_l.tx_busy;
   endproperty
   a_echo: assert property (p_echo) else $error("received byte not echoed");
   property p_hf0;
      state == ST_HOST && host_flag_zero |=> exec_valid && exec_addr == $past(start) && !busy;
   endproperty
   a_hf0: assert property (p_hf0) else $error("host flag zero did not end load");
   c_mode0: cover property (state == ST_IDLE && pend && mode == BML_MODE_EXP ##1 exec_valid);
   c_mem: cover property (state == ST_MEM ##1 exec_valid);
   c_ser: cover property (ser_l.tx_start);
   c_hf0: cover property (state == ST_HOST && host_flag_zero);
endmodule : bml_loader
`default_nettype wire

// ===== tb/bml_mem_model.sv
// Byte-wide boot memory holding a small load image.
`timescale 1ns/1ps
`default_nettype none
module bml_mem_model (
   // Clock.
   input wire logic aclk,
   // Memory port.
   input wire logic [17:0] ext_addr,
   input wire logic ext_rd,
   output logic [7:0] ext_data
);
   import bml_pkg::*;
   logic [7:0] image [0:11];
   logic [7:0] last = 8'h00;
   logic [17:0] idx;
   // Count 2, start 0x000123, words 0xa1b2c3 and 0x0d0e0f, low byte first.
   initial image = '{8'h02, 8'h00, 8'h00, 8'h23, 8'h01, 8'h00,
      8'hc3, 8'hb2, 8'ha1, 8'h0f, 8'h0e, 8'h0d};
   assign idx = ext_addr - BML_MEM_BASE[17:0];
   // Off a read the bus floats, so it shows the inverse of the last byte, never a stale copy.
   always_comb ext_data = !ext_rd ? ~last : (idx < 18'h0000c) ? image[idx[3:0]] : 8'h5a;
   always_ff @(posedge aclk) if (ext_rd) last <= ext_data;
endmodule : bml_mem_model
`default_nettype wire

// ===== tb/tb_bml_loader.sv
// Self-checking bench for the boot mode loader.
`timescale 1ns/1ps
`default_nettype none
module tb_bml_loader;
   import bml_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0, ext_data;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp;
   logic mode_pin_a = 0, mode_pin_b = 0, mode_pin_c = 0, mode_pin_d = 0;
   logic awready, wready, bvalid, arready, rvalid, ext_rd, ext_attr_one, ext_static;
   logic host_valid = 0, host_flag_zero = 0, host_ready, program_ram_we, exec_valid;
   logic [17:0] ext_addr;
   logic [4:0] ext_wait;
   logic [23:0] host_word = 0, program_ram_addr, program_ram_data, exec_addr, st, w;
   logic [47:0] exp_q[$], got_q[$];
   logic [1:0] sck = 0;
   logic ser_rxd = 1, ser_txd;
   logic [7:0] eb, sent_q[$], echo_q[$];
   logic [71:0] sv;
   int error_cnt = 0, samples_checked = 0, seed;
   bml_loader bml_loader_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .mode_pin_a, .mode_pin_b, .mode_pin_c, .mode_pin_d,
      .ext_addr, .ext_rd, .ext_attr_one, .ext_static, .ext_wait, .ext_data,
      .ser_clk(sck[1]), .ser_rxd, .ser_txd, .host_valid, .host_word, .host_ready,
      .host_flag_zero, .program_ram_we, .program_ram_addr, .program_ram_data, .exec_valid, .exec_addr);
   bml_mem_model bml_mem_model_i (.aclk, .ext_addr, .ext_rd, .ext_data);
   always #25 aclk = ~aclk;
   // The sender's 16x clock ticks every four clocks, so one bit cell is 64 clocks.
   always @(posedge aclk) sck <= sck + 2'h1;
   task chk(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Program writes are tagged with bit 47 clear, execution starts with it set.
   always @(posedge aclk) begin
      if (program_ram_we === 1'b1) got_q.push_back({1'b0, program_ram_addr[22:0], program_ram_data});
      if (exec_valid === 1'b1) got_q.push_back({24'h800000, exec_addr});
      if (ext_rd === 1'b1) chk({ext_attr_one, ext_wait}, 48'h3f);
   end
   task chk_q(input string name);
      int t;
      for (t = 0; t < 3000 && got_q.size() < exp_q.size(); t++) @(posedge aclk);
      repeat (3) @(posedge aclk);
      chk(got_q.size(), exp_q.size());
      while (exp_q.size() && got_q.size()) chk(got_q.pop_front(), exp_q.pop_front());
      exp_q.delete();
      got_q.delete();
      $display("test %s done", name);
   endtask : chk_q
   task do_reset(input logic [3:0] m);
      @(posedge aclk);
      {mode_pin_d, mode_pin_c, mode_pin_b, mode_pin_a} <= m;
      aresetn <= 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1;
   endtask : do_reset
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge aclk);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'b111};
      t = 0;
      // Each channel is released at the edge that takes it; bready stands until bvalid.
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 0;
         if (wready === 1'b1) wvalid <= 0;
      end while (bvalid !== 1'b1 && ++t < 100);
      chk({bvalid, bresp}, {1'b1, BML_RESP_OKAY});
      bready <= 0;
   endtask : axi_wr
   task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int t;
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      t = 0;
      do @(posedge aclk); while (arready !== 1'b1 && ++t < 100);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1'b1 && ++t < 100);
      chk({rvalid, rresp, rdata}, {1'b1, er, e});
      rready <= 0;
   endtask : axi_rd
   task host_put(input logic [23:0] v);
      int t;
      host_word <= v;
      host_valid <= 1;
      t = 0;
      do @(posedge aclk); while (host_ready !== 1'b1 && ++t < 100);
      chk(host_ready, 1'b1);
   endtask : host_put
   // One 8N1 frame, low bit first, with one extra idle cell so every echo can start.
   task ser_send(input logic [7:0] b);
      for (int i = 0; i < 11; i++) begin
         ser_rxd <= i == 0 ? 1'b0 : i < 9 ? b[i - 1] : 1'b1;
         repeat (64) @(posedge aclk);
      end
      sent_q.push_back(b);
   endtask : ser_send
   // Echo receiver: samples each of the eight data cells of the returned frame in its middle.
   initial forever begin
      @(negedge ser_txd);
      repeat (32) @(posedge aclk);
      for (int k = 0; k < 8; k++) begin
         repeat (64) @(posedge aclk);
         eb[k] = ser_txd;
      end
      echo_q.push_back(eb);
   end
   task conclude;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   initial begin
      #(50 * 20000);
      error_cnt++;
      conclude();
   end
   initial begin
      seed = $urandom(23);
      exp_q = '{{24'h000123, 24'ha1b2c3}, {24'h000124, 24'h0d0e0f}, {24'h800000, 24'h000123}};
      do_reset(BML_MODE_MEM);
      chk_q("byte_load");
      axi_rd(BML_OFF_MODE, 32'h1, BML_RESP_OKAY);
      axi_rd(8'h40, 32'h0, BML_RESP_SLVERR);
      axi_wr(BML_OFF_MODE, 32'h4);
      axi_wr(BML_OFF_CTRL, 32'h1);
      st = 24'($urandom) & 24'h000fff;
      host_put(24'h000003);
      host_put(st);
      for (int i = 0; i < 3; i++) begin
         w = 24'($urandom);
         exp_q.push_back({st + 24'(i), w});
         host_put(w);
      end
      host_valid <= 0;
      exp_q.push_back({24'h800000, st});
      chk_q("host_load");
      axi_wr(BML_OFF_CTRL, 32'h1);
      host_put(24'h000005);
      host_put(st + 24'h000100);
      host_put(24'h00beef);
      host_valid <= 0;
      host_flag_zero <= 1;
      exp_q = '{{st + 24'h000100, 24'h00beef}, {24'h800000, st + 24'h000100}};
      chk_q("host_stop");
      host_flag_zero <= 0;
      axi_wr(BML_OFF_MODE, 32'h2);
      axi_wr(BML_OFF_CTRL, 32'h1);
      sv = {24'($urandom), st + 24'h000200, 24'h000001};
      exp_q = '{{sv[47:24], sv[71:48]}, {24'h800000, sv[47:24]}};
      for (int i = 0; i < 9; i++) ser_send(sv[8 * i +: 8]);
      for (int t = 0; t < 2000 && echo_q.size() < 9; t++) @(posedge aclk);
      chk(echo_q.size(), 9);
      while (echo_q.size() && sent_q.size()) chk(echo_q.pop_front(), sent_q.pop_front());
      chk_q("serial_load");
      axi_rd(BML_OFF_START, {8'h0, sv[47:24]}, BML_RESP_OKAY);
      do_reset(4'hb);
      chk_q("reserved");
      axi_rd(BML_OFF_MODE, 32'hb, BML_RESP_OKAY);
      exp_q = '{{24'h800000, BML_EXP_START}};
      do_reset(BML_MODE_EXP);
      chk_q("expanded");
      chk({ext_static, ext_attr_one, ext_wait, ext_addr}, {2'b10, BML_WAIT_STATES, 18'h0});
      axi_rd(BML_OFF_MODE, 32'h0, BML_RESP_OKAY);
      axi_wr(BML_OFF_CTRL, 32'h1);
      chk_q("jump_skip");
      axi_rd(BML_OFF_STATUS, 32'h4, BML_RESP_OKAY);
      conclude();
   end
endmodule : tb_bml_loader
`default_nettype wire
